// ### verilog/iocc_consts.vh
// register map, field positions, reset values and timing counts of the oscillator clock control
`ifndef IOCC_CONSTS_VH
`define IOCC_CONSTS_VH

// register byte offsets on the apb bus
`define IOCC_OFS_CONTROL      8'h00
`define IOCC_OFS_TRIM         8'h04
`define IOCC_OFS_LF_CONTROL   8'h08
`define IOCC_OFS_CLK_SELECT   8'h0C
`define IOCC_OFS_IRQ_STATUS   8'h10
`define IOCC_OFS_IRQ_MASK     8'h14

// internal_osc_control fields
`define IOCC_CTL_ENABLE_BIT   7
`define IOCC_CTL_READY_BIT    6
`define IOCC_CTL_SUSPEND_BIT  5
`define IOCC_CTL_DIV_MSB      1
`define IOCC_CTL_DIV_LSB      0
`define IOCC_CTL_RESET        8'hC0

// divide select codes: 00 divides by 8, 11 by 1
`define IOCC_DIV_BY8          2'h0
`define IOCC_DIV_BY4          2'h1
`define IOCC_DIV_BY2          2'h2
`define IOCC_DIV_BY1          2'h3

// low_freq_osc_control fields
`define IOCC_LF_ENABLE_BIT    7
`define IOCC_LF_TRIM_MSB      5
`define IOCC_LF_TRIM_LSB      2
`define IOCC_LF_DIV_MSB       1
`define IOCC_LF_DIV_LSB       0
`define IOCC_LF_RESET         8'h00

// system clock source codes
`define IOCC_SRC_EXT          2'h0
`define IOCC_SRC_HF           2'h1
`define IOCC_SRC_LF           2'h2
`define IOCC_SRC_PLL          2'h3
`define IOCC_SRC_RESET        2'h1

// interrupt status bits
`define IOCC_IRQ_WAKE_BIT     0
`define IOCC_IRQ_READY_BIT    1
`define IOCC_IRQ_SUSP_BIT     2
`define IOCC_IRQ_WIDTH        3

// trim value that gives the nominal 24.5 MHz
`define IOCC_TRIM_FACTORY     7'h40

// timing
`define IOCC_PCLK_PERIOD_NS   50
`define IOCC_HF_SETTLE_NS     1000
`define IOCC_HF_SETTLE_CYC    ((`IOCC_HF_SETTLE_NS + `IOCC_PCLK_PERIOD_NS - 1) / `IOCC_PCLK_PERIOD_NS)

`endif

// ### verilog/iocc_sync.v
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module iocc_sync #(
    parameter W = 5
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // asynchronous inputs and their clean copy
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg out_reg;
            // s1 feeds s2 only, so metastability never reaches logic
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign sync_out[i] = out_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/iocc_clkdiv.v
// post-scaler that turns the running oscillator into a divided system clock tick
`timescale 1ns/1ns
`default_nettype none
`include "iocc_consts.vh"
module iocc_clkdiv (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // control
    input  wire       run,
    input  wire [1:0] div_sel,
    // divided clock tick, one pclk wide
    output reg        tick_reg,
    output reg  [1:0] div_active_reg
);
    reg  [2:0] cnt_reg;
    reg  [2:0] last;

    always @* begin
        case (div_active_reg)
            `IOCC_DIV_BY8: last = 3'h7;
            `IOCC_DIV_BY4: last = 3'h3;
            `IOCC_DIV_BY2: last = 3'h1;
            default:       last = 3'h0;
        endcase
    end

    // a new ratio is taken only at a period boundary, so no runt period ever appears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg        <= 3'h0;
            tick_reg       <= 1'b0;
            div_active_reg <= `IOCC_DIV_BY8;
        end else if (!run) begin
            cnt_reg  <= 3'h0;
            tick_reg <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg        <= 3'h0;
            tick_reg       <= 1'b1;
            div_active_reg <= div_sel;
        end else begin
            cnt_reg  <= cnt_reg + 3'h1;
            tick_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verilog/iocc_top.v
// internal oscillator clock control: registers, suspend and wake, post-scaler and interrupt
// Functional notes
// - reset selects the internal oscillator as source
// - software trims oscillator period, factory 24.5 MHz
// - system clock is oscillator divided 1/2/4/8
// - divide ratio resets to eight
// - writing suspend bit one halts the oscillator
// - suspended oscillator source stops core, peripheral clocks
// - wake on port match or enabled comparator low
// - wake restarts oscillator, core, peripherals regardless interrupt
// - core resumes after the suspending write
// - source may be external, either internal, pll
// - both oscillators post-scale; low one has control
// - control resets to C0: enable and ready set, suspend clear
// - ready reads one only when running settled
`timescale 1ns/1ns
`default_nettype none
`include "iocc_consts.vh"
module iocc_top #(
    parameter [6:0] TRIM_RESET = `IOCC_TRIM_FACTORY,
    parameter       SETTLE_CYC = `IOCC_HF_SETTLE_CYC
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // wake sources, asynchronous
    input  wire        port0_match,
    input  wire        port1_match,
    input  wire        port2_match,
    input  wire        cmp0_out,
    input  wire        cmp1_out,
    // comparator enables from pclk logic
    input  wire        cmp0_enable,
    input  wire        cmp1_enable,
    // oscillator and clock controls
    output reg         hf_osc_enable,
    output reg         hf_osc_run,
    output reg  [6:0]  hf_osc_trim,
    output reg         lf_osc_enable,
    output reg  [3:0]  lf_osc_trim,
    output reg  [1:0]  lf_osc_div,
    output reg  [1:0]  system_clock_source,
    output wire        system_clock_tick,
    output reg         core_clock_run,
    output reg         periph_clock_run,
    // interrupt
    output reg         irq
);
    // reset words kept at full width so single bits can be picked cleanly
    localparam [7:0] CTL_RESET = `IOCC_CTL_RESET;
    localparam [7:0] LF_RESET  = `IOCC_LF_RESET;

    // register state
    reg        hf_en_reg;
    reg        suspend_reg;
    reg  [1:0] div_sel_reg;
    reg        ready_reg;
    reg  [6:0] trim_reg;
    reg        lf_en_reg;
    reg  [3:0] lf_trim_reg;
    reg  [1:0] lf_div_reg;
    reg  [1:0] src_reg;
    reg  [`IOCC_IRQ_WIDTH-1:0] status_reg;
    reg  [`IOCC_IRQ_WIDTH-1:0] mask_reg;
    reg  [15:0] settle_reg;
    reg        halted_reg;

    reg  [31:0] rdata_next;
    reg         mapped;
    reg  [`IOCC_IRQ_WIDTH-1:0] status_next;
    reg  [15:0] settle_next;

    wire [4:0] wake_sync;
    wire [1:0] div_active;
    wire       access;
    wire       wr_en;
    wire       wake;
    wire       osc_on;
    wire       ready_next;

    // apb: one wait state, pready and data come from flops
    assign access = psel & penable & ~pready;
    assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

    // level events; a match or a low enabled comparator keeps waking
    iocc_sync #(
        .W(5)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in({cmp1_out, cmp0_out, port2_match, port1_match, port0_match}),
        .sync_out(wake_sync)
    );

    assign wake = wake_sync[0] | wake_sync[1] | wake_sync[2]
                | (cmp0_enable & ~wake_sync[3])
                | (cmp1_enable & ~wake_sync[4]);

    // the oscillator runs only while enabled and not suspended
    assign osc_on = hf_en_reg & ~suspend_reg;

    iocc_clkdiv u_div (
        .pclk          (pclk),
        .presetn       (presetn),
        .run           (osc_on),
        .div_sel       (div_sel_reg),
        .tick_reg      (system_clock_tick),
        .div_active_reg(div_active)
    );

    // address decode and read mux
    always @* begin
        rdata_next = 32'h0000_0000;
        mapped     = 1'b1;
        case (paddr)
            `IOCC_OFS_CONTROL: begin
                rdata_next[`IOCC_CTL_ENABLE_BIT]                 = hf_en_reg;
                rdata_next[`IOCC_CTL_READY_BIT]                  = ready_reg;
                rdata_next[`IOCC_CTL_SUSPEND_BIT]                = suspend_reg;
                rdata_next[`IOCC_CTL_DIV_MSB:`IOCC_CTL_DIV_LSB] = div_sel_reg;
            end
            `IOCC_OFS_TRIM: begin
                rdata_next[6:0] = trim_reg;
            end
            `IOCC_OFS_LF_CONTROL: begin
                rdata_next[`IOCC_LF_ENABLE_BIT]                 = lf_en_reg;
                rdata_next[`IOCC_LF_TRIM_MSB:`IOCC_LF_TRIM_LSB] = lf_trim_reg;
                rdata_next[`IOCC_LF_DIV_MSB:`IOCC_LF_DIV_LSB]   = lf_div_reg;
            end
            `IOCC_OFS_CLK_SELECT: begin
                rdata_next[1:0] = src_reg;
            end
            `IOCC_OFS_IRQ_STATUS: begin
                rdata_next[`IOCC_IRQ_WIDTH-1:0] = status_reg;
            end
            `IOCC_OFS_IRQ_MASK: begin
                rdata_next[`IOCC_IRQ_WIDTH-1:0] = mask_reg;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            if (access && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    // software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_en_reg   <= CTL_RESET[`IOCC_CTL_ENABLE_BIT];
            div_sel_reg <= `IOCC_DIV_BY8;
            trim_reg    <= TRIM_RESET;
            lf_en_reg   <= LF_RESET[`IOCC_LF_ENABLE_BIT];
            lf_trim_reg <= 4'h0;
            lf_div_reg  <= 2'h0;
            src_reg     <= `IOCC_SRC_RESET;
            mask_reg    <= {`IOCC_IRQ_WIDTH{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `IOCC_OFS_CONTROL: begin
                    hf_en_reg   <= pwdata[`IOCC_CTL_ENABLE_BIT];
                    div_sel_reg <= pwdata[`IOCC_CTL_DIV_MSB:`IOCC_CTL_DIV_LSB];
                end
                `IOCC_OFS_TRIM: begin
                    trim_reg <= pwdata[6:0];
                end
                `IOCC_OFS_LF_CONTROL: begin
                    lf_en_reg   <= pwdata[`IOCC_LF_ENABLE_BIT];
                    lf_trim_reg <= pwdata[`IOCC_LF_TRIM_MSB:`IOCC_LF_TRIM_LSB];
                    lf_div_reg  <= pwdata[`IOCC_LF_DIV_MSB:`IOCC_LF_DIV_LSB];
                end
                `IOCC_OFS_CLK_SELECT: begin
                    src_reg <= pwdata[1:0];
                end
                `IOCC_OFS_IRQ_MASK: begin
                    mask_reg <= pwdata[`IOCC_IRQ_WIDTH-1:0];
                end
                default: begin
                    hf_en_reg <= hf_en_reg;
                end
            endcase
        end
    end

    // suspend: set by software, cleared by any wake level
    // a write of one while a wake level is present is dropped at once, so the
    // core never stalls on a condition that is already true
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_reg <= 1'b0;
        end else if (wake) begin
            suspend_reg <= 1'b0;
        end else if (wr_en && paddr == `IOCC_OFS_CONTROL
                     && pwdata[`IOCC_CTL_SUSPEND_BIT]) begin
            suspend_reg <= 1'b1;
        end
    end

    // ready: counts settle time after each start, drops at once on stop
    always @* begin
        settle_next = settle_reg;
        if (!osc_on) begin
            settle_next = 16'h0000;
        end else if (!ready_reg) begin
            settle_next = settle_reg + 16'h0001;
        end
    end

    assign ready_next = osc_on & (ready_reg | (settle_reg >= SETTLE_CYC[15:0] - 16'h0001));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_reg <= 16'h0000;
            ready_reg  <= CTL_RESET[`IOCC_CTL_READY_BIT];
        end else begin
            settle_reg <= ready_next ? 16'h0000 : settle_next;
            ready_reg  <= ready_next;
        end
    end

    // clock gating: only a suspended oscillator that feeds the system stops
    // the core; the core simply stalls, so it continues with the next
    // instruction after the suspending write once the clocks return
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted_reg       <= 1'b0;
            core_clock_run   <= 1'b1;
            periph_clock_run <= 1'b1;
        end else begin
            halted_reg       <= suspend_reg & (src_reg == `IOCC_SRC_HF);
            core_clock_run   <= ~(suspend_reg & (src_reg == `IOCC_SRC_HF));
            periph_clock_run <= ~(suspend_reg & (src_reg == `IOCC_SRC_HF));
        end
    end

    // interrupt status: hardware set wins over a write-one clear
    always @* begin
        status_next = status_reg;
        if (wr_en && paddr == `IOCC_OFS_IRQ_STATUS) begin
            status_next = status_reg & ~pwdata[`IOCC_IRQ_WIDTH-1:0];
        end
        if (suspend_reg && wake) begin
            status_next[`IOCC_IRQ_WAKE_BIT] = 1'b1;
        end
        if (ready_next && !ready_reg) begin
            status_next[`IOCC_IRQ_READY_BIT] = 1'b1;
        end
        if (halted_reg == 1'b0 && suspend_reg && src_reg == `IOCC_SRC_HF) begin
            status_next[`IOCC_IRQ_SUSP_BIT] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= {`IOCC_IRQ_WIDTH{1'b0}};
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq        <= |(status_next & mask_reg);
        end
    end

    // control outputs straight from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_osc_enable       <= 1'b1;
            hf_osc_run          <= 1'b1;
            hf_osc_trim         <= TRIM_RESET;
            lf_osc_enable       <= 1'b0;
            lf_osc_trim         <= 4'h0;
            lf_osc_div          <= 2'h0;
            system_clock_source <= `IOCC_SRC_RESET;
        end else begin
            hf_osc_enable       <= hf_en_reg;
            hf_osc_run          <= osc_on;
            hf_osc_trim         <= trim_reg;
            lf_osc_enable       <= lf_en_reg;
            lf_osc_trim         <= lf_trim_reg;
            lf_osc_div          <= lf_div_reg;
            system_clock_source <= src_reg;
        end
    end

    // software must keep these: leave pll before suspend
    // reinitialise pll after wake; the block does not police the source
    wire unused_ok = &{1'b0, div_active};
endmodule
`default_nettype wire

// ### verif/iocc_monitor.sv
// port checker for the oscillator clock control
`timescale 1ns/1ns
`default_nettype none
module iocc_monitor #(
    parameter [6:0] TRIM_RESET = 7'h40
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // wake sources
    input wire logic        port0_match,
    input wire logic        port1_match,
    input wire logic        port2_match,
    input wire logic        cmp0_out,
    input wire logic        cmp1_out,
    input wire logic        cmp0_enable,
    input wire logic        cmp1_enable,
    // clock controls
    input wire logic        hf_osc_enable,
    input wire logic        hf_osc_run,
    input wire logic [6:0]  hf_osc_trim,
    input wire logic [1:0]  system_clock_source,
    input wire logic        system_clock_tick,
    input wire logic        core_clock_run,
    input wire logic        periph_clock_run
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wake_any = port0_match | port1_match | port2_match |
                    (cmp0_enable & ~cmp0_out) | (cmp1_enable & ~cmp1_out);
    answer_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not one cycle after access");
    slverr_unmapped_a: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without slverr");
    reset_source_a: assert property ($rose(presetn) |-> system_clock_source == 2'h1)
        else $error("reset source not internal oscillator");
    reset_trim_a: assert property ($rose(presetn) |-> hf_osc_trim == TRIM_RESET && hf_osc_enable)
        else $error("reset trim or enable wrong");
    first_tick_a: assert property ($rose(presetn) |-> !system_clock_tick [*5] ##[1:4] system_clock_tick)
        else $error("first tick not at divide by eight");
    osc_off_a: assert property (!hf_osc_enable |-> !hf_osc_run)
        else $error("oscillator runs while disabled");
    core_periph_a: assert property (core_clock_run == periph_clock_run)
        else $error("core and peripheral run differ");
    core_stop_a: assert property (!core_clock_run |-> !hf_osc_run && system_clock_source == 2'h1)
        else $error("core stopped without hf suspend");
    wake_resume_a: assert property (wake_any && !core_clock_run |-> ##[1:10] core_clock_run)
        else $error("wake event did not restart clocks");
    wake_together_a: assert property ($rose(core_clock_run) |-> hf_osc_run)
        else $error("core restarted before oscillator");
    ready_low_a: assert property (pready && !pwrite && paddr == 8'h00 && !hf_osc_run &&
        !$past(hf_osc_run) && !$past(hf_osc_run, 2) |-> !prdata[6])
        else $error("ready read high while halted");
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the oscillator clock control
`timescale 1ns/1ns
`default_nettype none
`include "iocc_consts.vh"
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        port0_match = 1'b0;
    logic        port1_match = 1'b0;
    logic        port2_match = 1'b0;
    logic        cmp0_out = 1'b1;
    logic        cmp1_out = 1'b1;
    logic        cmp0_enable = 1'b0;
    logic        cmp1_enable = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, hf_osc_enable, hf_osc_run, lf_osc_enable;
    wire  [6:0]  hf_osc_trim;
    wire  [3:0]  lf_osc_trim;
    wire  [1:0]  lf_osc_div, system_clock_source;
    wire         system_clock_tick, core_clock_run, periph_clock_run, irq;
    int          err_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          p;
    logic [31:0] d;
    logic        e;

    iocc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0_match(port0_match), .port1_match(port1_match),
        .port2_match(port2_match), .cmp0_out(cmp0_out), .cmp1_out(cmp1_out),
        .cmp0_enable(cmp0_enable), .cmp1_enable(cmp1_enable), .hf_osc_enable(hf_osc_enable),
        .hf_osc_run(hf_osc_run), .hf_osc_trim(hf_osc_trim), .lf_osc_enable(lf_osc_enable),
        .lf_osc_trim(lf_osc_trim), .lf_osc_div(lf_osc_div),
        .system_clock_source(system_clock_source), .system_clock_tick(system_clock_tick),
        .core_clock_run(core_clock_run), .periph_clock_run(periph_clock_run), .irq(irq));

    always #25 pclk = ~pclk;

    // the whole run needs about 700 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered just after a rising edge; two idle cycles follow so strobes never double up
    // and outputs copied from the written register have settled before any compare
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) err_count++;
        repeat (2) @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, d, exp);
    endtask

    task automatic period;
        p = 0;
        while (system_clock_tick !== 1'b1) @(posedge pclk);
        do begin
            @(posedge pclk);
            p++;
        end while (system_clock_tick !== 1'b1 && p < 20);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IOCC_OFS_CONTROL, 32'hC0, "control reset");
        rd(`IOCC_OFS_TRIM, 32'h40, "trim reset");
        rd(`IOCC_OFS_CLK_SELECT, 32'h1, "source reset");
        rd(`IOCC_OFS_LF_CONTROL, 32'h0, "lf reset");
        rd(`IOCC_OFS_IRQ_MASK, 32'h0, "mask reset");
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped slverr", e, 1'b1);
        wr(`IOCC_OFS_CONTROL, 32'h9F);
        rd(`IOCC_OFS_CONTROL, 32'hC3, "reserved bits");
        wr(`IOCC_OFS_TRIM, 32'h15);
        check("trim pins", hf_osc_trim, 7'h15);
        wr(`IOCC_OFS_LF_CONTROL, 32'hF6);
        check("lf pins", {lf_osc_enable, lf_osc_trim, lf_osc_div}, 7'h76);
        for (int s = 0; s < 4; s++) begin
            wr(`IOCC_OFS_CLK_SELECT, s);
            check("source pins", system_clock_source, s);
        end
        wr(`IOCC_OFS_CLK_SELECT, 32'h1);
        $display("test registers done");
        // walk divide codes from eight down to one, then back to eight
        for (int c = 0; c < 5; c++) begin
            wr(`IOCC_OFS_CONTROL, 32'h80 | (c % 4));
            period();
            period();
            check("tick period", p, 8 >> (c % 4));
        end
        $display("test divider done");
        wr(`IOCC_OFS_CONTROL, 32'h0);
        rd(`IOCC_OFS_CONTROL, 32'h0, "disabled control");
        check("osc disabled", {hf_osc_enable, hf_osc_run}, 2'h0);
        for (int w = 0; w < 6; w++) begin
            wr(`IOCC_OFS_CLK_SELECT, w == 5 ? 32'h2 : 32'h1);
            wr(`IOCC_OFS_IRQ_MASK, w < 4 ? 32'h7 : 32'h0);
            cmp0_out <= (w != 3);
            cmp1_enable <= (w == 4);
            wr(`IOCC_OFS_CONTROL, 32'hA0);
            repeat (10) @(posedge pclk);
            check("osc halted", hf_osc_run, 1'b0);
            check("core run", core_clock_run, w == 5);
            rd(`IOCC_OFS_CONTROL, 32'hA0, "suspended control");
            case (w)
                0, 5: port0_match <= 1'b1;
                1: port1_match <= 1'b1;
                2: port2_match <= 1'b1;
                3: cmp0_enable <= 1'b1;
                default: cmp1_out <= 1'b0;
            endcase
            p = 0;
            do begin
                @(posedge pclk);
                p++;
            end while (hf_osc_run !== 1'b1 && p < 20);
            check("core woke", core_clock_run, 1'b1);
            rd(`IOCC_OFS_CONTROL, 32'h80, "woken control");
            port0_match <= 1'b0;
            port1_match <= 1'b0;
            port2_match <= 1'b0;
            cmp0_enable <= 1'b0;
            cmp1_out <= 1'b1;
            repeat (30) @(posedge pclk);
            rd(`IOCC_OFS_CONTROL, 32'hC0, "settled control");
            rd(`IOCC_OFS_IRQ_STATUS, w == 5 ? 32'h3 : 32'h7, "status");
            check("irq", irq, w < 4);
            wr(`IOCC_OFS_IRQ_STATUS, 32'h7);
            @(posedge pclk);
            check("irq cleared", irq, 1'b0);
        end
        $display("test suspend done");
        summarize();
    end
endmodule

bind iocc_top iocc_monitor #(.TRIM_RESET(TRIM_RESET)) mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port0_match(port0_match),
    .port1_match(port1_match), .port2_match(port2_match), .cmp0_out(cmp0_out),
    .cmp1_out(cmp1_out), .cmp0_enable(cmp0_enable), .cmp1_enable(cmp1_enable),
    .hf_osc_enable(hf_osc_enable), .hf_osc_run(hf_osc_run), .hf_osc_trim(hf_osc_trim),
    .system_clock_source(system_clock_source), .system_clock_tick(system_clock_tick),
    .core_clock_run(core_clock_run), .periph_clock_run(periph_clock_run));
`default_nettype wire
